// ### src/ppl_password_lock.sv
// Password lock over the parameter store: permission checks and lock state.
// Assumes gating inputs from the parameter store and one request per cycle.
// Request fields only matter while valid; every output is registered.
`timescale 1ns/1ps
module ppl_password_lock
    import ppl_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      rst_b,
    input  wire logic      clk_en,
    input  wire ppl_req_t  req,
    input  wire ppl_gate_t gate,
    output ppl_rsp_t       rsp_q,
    output logic           option_fault_trip_q,
    output logic           params_reset_q,
    output logic           jog_screen_hide_q,
    output logic [15:0]    level_q,
    output logic           registered_q
);
    typedef enum logic [1:0] {PPL_ST_OPEN, PPL_ST_REG, PPL_ST_DEAD} ppl_state_t;

    ppl_state_t  state_q;
    logic [15:0] pw_q;
    logic [2:0]  err_cnt_q;
    ppl_state_t  state_d;
    logic [15:0] pw_d;
    logic [2:0]  err_cnt_d;

    logic [15:0] lvl_d;
    logic        counting;
    logic        restricted;
    logic [5:0]  allow;
    logic [2:0]  src_rd;
    logic [2:0]  src_wr;
    logic        perm_rd;
    logic        perm_wr;
    logic        pw_ok;
    logic        is_wr;
    logic        is_rd;
    logic        grant;
    logic        pw_refuse;
    logic        entry_noop;
    logic        entry_reg;
    logic        entry_try;
    logic        all_clear_ok;
    logic [15:0] entry_rd;
    logic [15:0] rd_val;
    logic        level_legal;
    logic        level_wr;
    logic        unlock_hit;
    logic        trip_level;
    logic        hide_level;

    // Level index 0..6, either range
    always_comb begin
        if (level_q >= PPL_LVL_HI_OFS && level_q <= PPL_LVL_HI_OFS + PPL_LVL_LO_MAX) begin
            lvl_d    = level_q - PPL_LVL_HI_OFS;
            counting = 1'b1;
        end else begin
            lvl_d    = level_q;
            counting = 1'b0;
        end
    end

    // Bits: local r/w, rs485 r/w, option r/w
    always_comb begin
        if (level_q == PPL_NO_LOCK) begin
            allow = 6'h3F;
        end else begin
            case (lvl_d[2:0])
                3'h0:    allow = 6'h00;
                3'h1:    allow = 6'h15;
                3'h2:    allow = 6'h3D;
                3'h3:    allow = 6'h17;
                3'h4:    allow = 6'h10;
                3'h5:    allow = 6'h3C;
                3'h6:    allow = 6'h13;
                default: allow = 6'h00;
            endcase
        end
    end

    // One read/write pair per source class
    for (genvar k = 0; k < 3; k++) begin : g_src
        assign src_rd[k] = allow[2*k];
        assign src_wr[k] = allow[2*k+1];
    end

    assign restricted = (state_q != PPL_ST_OPEN) && (level_q != PPL_NO_LOCK);

    // Source class selects its read/write pair
    always_comb begin
        case (req.src)
            PPL_SRC_LOCAL: begin
                perm_rd = src_rd[0];
                perm_wr = src_wr[0];
            end
            PPL_SRC_RS485: begin
                perm_rd = src_rd[1];
                perm_wr = src_wr[1];
            end
            default: begin
                perm_rd = src_rd[2];
                perm_wr = src_wr[2];
            end
        endcase
    end

    assign is_wr = req.valid && req.write;
    assign is_rd = req.valid && !req.write;

    // Password matrix verdict for ordinary parameters
    always_comb begin
        if (!restricted) begin
            pw_ok = 1'b1;
        end else if (req.tgt == PPL_TGT_CONTRAST && gate.panel_unit_fitted) begin
            pw_ok = 1'b1;
        end else if (req.tgt != PPL_TGT_OTHER && req.tgt != PPL_TGT_CONTRAST) begin
            pw_ok = 1'b1;
        end else begin
            pw_ok = req.write ? perm_wr : perm_rd;
        end
    end

    assign pw_refuse = req.valid && !pw_ok;

    assign entry_noop = is_wr && req.tgt == PPL_TGT_ENTRY
                        && (req.wdata == PPL_ZERO || req.wdata == PPL_NO_LOCK);
    assign entry_reg  = is_wr && req.tgt == PPL_TGT_ENTRY && !entry_noop
                        && state_q == PPL_ST_OPEN && level_q != PPL_NO_LOCK
                        && req.wdata >= PPL_PW_MIN && req.wdata <= PPL_PW_MAX;
    assign entry_try  = is_wr && req.tgt == PPL_TGT_ENTRY && !entry_noop
                        && state_q != PPL_ST_OPEN;
    assign all_clear_ok = is_wr && req.tgt == PPL_TGT_ALL_CLEAR
                          && !gate.running && !gate.write_blocked;
    assign unlock_hit = entry_try && state_q == PPL_ST_REG && req.wdata == pw_q;

    // Level codes behind the trip and the screen suppression
    assign trip_level = lvl_d == PPL_ZERO;
    assign hide_level = lvl_d == 16'h0004 || lvl_d == 16'h0005;

    // Final grant including the special targets
    always_comb begin
        grant = pw_ok;
        case (req.tgt)
            PPL_TGT_LEVEL: begin
                if (req.write) begin
                    grant = gate.disp_ext_zero && !gate.write_blocked
                            && state_q == PPL_ST_OPEN;
                end else begin
                    grant = gate.disp_ext_zero || req.src != PPL_SRC_LOCAL;
                end
            end
            PPL_TGT_ENTRY: begin
                if (req.write) begin
                    if (level_q == PPL_NO_LOCK) begin
                        grant = 1'b0;
                    end else if (state_q == PPL_ST_OPEN) begin
                        grant = entry_noop || entry_reg;
                    end else begin
                        grant = 1'b1;
                    end
                end else begin
                    grant = gate.disp_ext_zero || restricted
                            || req.src != PPL_SRC_LOCAL;
                end
            end
            PPL_TGT_CLEAR: begin
                grant = !gate.write_blocked && !gate.running
                        && (!restricted || req.src != PPL_SRC_LOCAL);
            end
            PPL_TGT_ALL_CLEAR: begin
                grant = all_clear_ok;
            end
            PPL_TGT_COPY: begin
                grant = !restricted;
            end
            default: begin
                if (req.write && gate.write_blocked) begin
                    grant = 1'b0;
                end else if (!req.write && gate.read_blocked
                             && req.src == PPL_SRC_LOCAL) begin
                    grant = 1'b0;
                end
            end
        endcase
    end

    // Entry parameter read value
    always_comb begin
        if (state_q == PPL_ST_OPEN) begin
            entry_rd = PPL_RST_ENTRY;
        end else if (counting) begin
            entry_rd = {13'h0000, err_cnt_q};
        end else begin
            entry_rd = PPL_ZERO;
        end
    end

    // Read data toward the source; zero unless a granted lock read
    always_comb begin
        rd_val = PPL_ZERO;
        if (is_rd && grant) begin
            if (req.tgt == PPL_TGT_LEVEL) begin
                rd_val = level_q;
            end else if (req.tgt == PPL_TGT_ENTRY) begin
                rd_val = entry_rd;
            end
        end
    end

    // Only the documented level codes are kept
    always_comb begin
        if (req.wdata == PPL_NO_LOCK || req.wdata <= PPL_LVL_LO_MAX) begin
            level_legal = 1'b1;
        end else if (req.wdata >= PPL_LVL_HI_OFS
                     && req.wdata <= PPL_LVL_HI_OFS + PPL_LVL_LO_MAX) begin
            level_legal = 1'b1;
        end else begin
            level_legal = 1'b0;
        end
    end

    assign level_wr = is_wr && req.tgt == PPL_TGT_LEVEL && grant;

    // Lock level register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            level_q <= PPL_RST_LEVEL;
        end else if (clk_en) begin
            if (all_clear_ok) begin
                level_q <= PPL_RST_LEVEL;
            end else if (level_wr && level_legal) begin
                level_q <= req.wdata;
            end
        end
    end

    // Next lock state, stored password and error count
    always_comb begin
        state_d   = state_q;
        pw_d      = pw_q;
        err_cnt_d = err_cnt_q;
        if (all_clear_ok) begin
            state_d   = PPL_ST_OPEN;
            pw_d      = PPL_RST_ENTRY;
            err_cnt_d = 3'h0;
        end else if (entry_reg) begin
            state_d = PPL_ST_REG;
            pw_d    = req.wdata;
        end else if (entry_try && state_q == PPL_ST_REG) begin
            if (unlock_hit) begin
                state_d   = PPL_ST_OPEN;
                pw_d      = PPL_RST_ENTRY;
                err_cnt_d = 3'h0;
            end else if (counting) begin
                err_cnt_d = err_cnt_q + 3'h1;
                if (err_cnt_d == PPL_ERR_LIMIT) begin
                    state_d = PPL_ST_DEAD;
                end
            end
        end
    end

    // Lock state and its status output move on the same edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q      <= PPL_ST_OPEN;
            registered_q <= 1'b0;
        end else if (clk_en) begin
            state_q      <= state_d;
            registered_q <= state_d != PPL_ST_OPEN;
        end
    end

    // Stored password
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pw_q <= PPL_RST_ENTRY;
        end else if (clk_en) begin
            pw_q <= pw_d;
        end
    end

    // Unlock error count
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            err_cnt_q <= 3'h0;
        end else if (clk_en) begin
            err_cnt_q <= err_cnt_d;
        end
    end

    // Response toward the requesting source
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_q <= '0;
        end else if (clk_en) begin
            rsp_q.valid      <= req.valid;
            rsp_q.granted    <= req.valid && grant;
            rsp_q.lock_err   <= pw_refuse;
            rsp_q.unlock_err <= entry_try && !unlock_hit;
            rsp_q.rdata      <= rd_val;
        end
    end

    // Option fault trip while fully locked with an option fitted
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            option_fault_trip_q <= 1'b0;
        end else if (clk_en) begin
            option_fault_trip_q <= restricted && trip_level
                                   && gate.option_fitted;
        end
    end

    // One-cycle pulse that resets the parameter store
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            params_reset_q <= 1'b0;
        end else if (clk_en) begin
            params_reset_q <= all_clear_ok;
        end
    end

    // Jog speed screen suppression
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            jog_screen_hide_q <= 1'b0;
        end else if (clk_en) begin
            jog_screen_hide_q <= restricted && hide_level;
        end
    end

    // Internally maintained values bypass this block entirely
endmodule

// ### src/ppl_pkg.sv
// Package for the parameter password lock: values, codes and carrier types.
// Assumes one core clock domain; all requests arrive synchronous to it.
// What this block does
// - Lock level 9999 means no lock; 0-6 and 100-106 pick a restriction level.
// - Writing 1000..9998 to the entry parameter registers a password and restricts.
// - With lock level 9999, writes to the entry parameter are refused.
// - Accesses are classed as local panel, RS-485 network or option network.
// - Read/write permission per source follows the level matrix.
// - Display-extension and write-protect selections can still deny granted access.
// - Level 0 or 100 with an option fitted raises the option fault trip.
// - Levels 0-6 read 0 and count nothing; 100-106 count errors to five.
// - After five errors at levels 100-106 only an all clear unlocks.
// - Once registered, the entry parameter reads 0 to 5, never the password.
// - Writing 0 or 9999 to the entry parameter changes nothing; it is accepted unless the lock level is 9999.
// - Correct password unlocks; a wrong one signals an error and stays locked.
// - All clear removes the lock and resets parameters; refused while running.
// - While registered: no lock level writes, no copy, clear only via network.
// - Network reads ignore the display-extension read restriction.
// - Any access refused by the password raises the lock error indication.
// - Device-maintained values like parts life still update while locked.
// - Contrast parameter stays accessible under any lock with the panel unit fitted.
// - Levels 4, 5, 104, 105 hide the jog speed screen on the panel unit.
package ppl_pkg;
    localparam logic [15:0] PPL_NO_LOCK    = 16'h270F;
    localparam logic [15:0] PPL_PW_MIN     = 16'h03E8;
    localparam logic [15:0] PPL_PW_MAX     = 16'h270E;
    localparam logic [15:0] PPL_LVL_HI_OFS = 16'h0064;
    localparam logic [15:0] PPL_LVL_LO_MAX = 16'h0006;
    localparam logic [15:0] PPL_ZERO       = 16'h0000;
    localparam logic [2:0]  PPL_ERR_LIMIT  = 3'h5;
    localparam logic [15:0] PPL_RST_LEVEL  = 16'h270F;
    localparam logic [15:0] PPL_RST_ENTRY  = 16'h270F;

    typedef enum logic [1:0] {
        PPL_SRC_LOCAL,
        PPL_SRC_RS485,
        PPL_SRC_OPTION
    } ppl_src_t;

    typedef enum logic [2:0] {
        PPL_TGT_LEVEL,
        PPL_TGT_ENTRY,
        PPL_TGT_CONTRAST,
        PPL_TGT_OTHER,
        PPL_TGT_CLEAR,
        PPL_TGT_ALL_CLEAR,
        PPL_TGT_COPY
    } ppl_tgt_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        ppl_src_t    src;
        ppl_tgt_t    tgt;
        logic [15:0] wdata;
    } ppl_req_t;

    typedef struct packed {
        logic        valid;
        logic        granted;
        logic        lock_err;
        logic        unlock_err;
        logic [15:0] rdata;
    } ppl_rsp_t;

    typedef struct packed {
        logic disp_ext_zero;
        logic read_blocked;
        logic write_blocked;
        logic running;
        logic option_fitted;
        logic panel_unit_fitted;
    } ppl_gate_t;
endpackage

// ### tb/ppl_host_model.sv
// Requesting party model: panel, RS-485 host or option.
// Assumes the bench sets cmd and go off the rising edge.
`timescale 1ns/1ps
module ppl_host_model
    import ppl_pkg::*;
(
    input  wire logic     core_clk,
    input  wire logic     go,
    input  wire ppl_req_t cmd,
    output ppl_req_t      req
);
    logic [15:0] junk_q = 16'h0000;

    always @(posedge core_clk) begin
        junk_q <= ~junk_q + 16'h0001;
    end
    // Idle bus carries junk that stays at zero, never the last request
    assign req = go ? cmd : {1'b0, junk_q[0], PPL_SRC_LOCAL, PPL_TGT_OTHER, junk_q};
endmodule

// ### tb/ppl_password_lock_chk.sv
// Checker on the password lock ports.
// Assumes one core clock and the async active-low reset.
`timescale 1ns/1ps
module ppl_password_lock_chk
    import ppl_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        clk_en,
    input wire ppl_req_t    req,
    input wire ppl_gate_t   gate,
    input wire ppl_rsp_t    rsp_q,
    input wire logic        option_fault_trip_q,
    input wire logic        params_reset_q,
    input wire logic        jog_screen_hide_q,
    input wire logic [15:0] level_q,
    input wire logic        registered_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic take;
    logic wr;

    assign take = clk_en && req.valid;
    assign wr   = take && req.write;

    rsp_pulse_a: assert property (take |=> rsp_q.valid)
        else $error("response missing");
    entry_refused_a: assert property (wr && req.tgt == PPL_TGT_ENTRY && level_q == PPL_NO_LOCK
        |=> !rsp_q.granted && !registered_q) else $error("entry write taken without lock");
    entry_hidden_a: assert property (take && !req.write && req.tgt == PPL_TGT_ENTRY
        && registered_q |=> rsp_q.rdata <= 16'h0005) else $error("entry read above 5");
    level_frozen_a: assert property (wr && req.tgt == PPL_TGT_LEVEL && registered_q
        |=> !rsp_q.granted && $stable(level_q)) else $error("level changed while registered");
    lock_err_a: assert property (rsp_q.lock_err |-> rsp_q.valid && !rsp_q.granted)
        else $error("lock error on granted access");
    clear_running_a: assert property (wr && req.tgt == PPL_TGT_ALL_CLEAR && gate.running
        |=> !params_reset_q && !rsp_q.granted) else $error("all clear while running");
    trip_level_a: assert property ((clk_en && registered_q && gate.option_fitted
        && (level_q == 16'h0000 || level_q == 16'h0064)) [*2] |-> option_fault_trip_q)
        else $error("option trip missing");
    jog_hide_a: assert property ((clk_en && registered_q && (level_q == 16'h0004
        || level_q == 16'h0005 || level_q == 16'h0068 || level_q == 16'h0069)) [*2]
        |-> jog_screen_hide_q) else $error("jog screen not hidden");

    cover property (rsp_q.unlock_err);
    cover property (params_reset_q);
    cover property (rsp_q.lock_err);
endmodule

bind ppl_password_lock ppl_password_lock_chk u_chk (.core_clk, .rst_b, .clk_en, .req, .gate,
    .rsp_q, .option_fault_trip_q, .params_reset_q, .jog_screen_hide_q, .level_q, .registered_q);

// ### tb/test_parameter_password_lock.sv
// Bench for the password lock: access tasks and checked sequences.
// Assumes the host model drives requests and the checker is bound.
`timescale 1ns/1ps
module test_parameter_password_lock
    import ppl_pkg::*;
;
    localparam logic [15:0] PW  = 16'h04D2;
    localparam logic [15:0] BAD = 16'h0457;
    logic        core_clk = 1'b0;
    logic        rst_b    = 1'b0;
    logic        go       = 1'b0;
    logic        clk_en   = 1'b1;
    ppl_req_t    cmd      = '0;
    ppl_gate_t   gate     = '0;
    ppl_req_t    req;
    ppl_rsp_t    rsp_q;
    logic        trip;
    logic        prst;
    logic        jog;
    logic        reg_q;
    logic [15:0] level_q;
    int          err_count = 0;
    int          compares  = 0;
    logic [15:0] lv [4] = '{16'h0004, 16'h0069, 16'h0000, 16'h0064};

`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end

    always #25 core_clk = ~core_clk;

    ppl_host_model u_host (.core_clk(core_clk), .go(go), .cmd(cmd), .req(req));
    ppl_password_lock u_dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .req(req),
        .gate(gate), .rsp_q(rsp_q), .option_fault_trip_q(trip), .params_reset_q(prst),
        .jog_screen_hide_q(jog), .level_q(level_q), .registered_q(reg_q));

    task automatic report_and_stop();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic acc(logic wr, ppl_src_t s, ppl_tgt_t t, logic [15:0] d);
        int i;
        @(negedge core_clk);
        cmd = '{1'b1, wr, s, t, d};
        go = 1'b1;
        @(negedge core_clk);
        go = 1'b0;
        for (i = 0; i < 3 && rsp_q.valid !== 1'b1; i++) @(negedge core_clk);
        if (rsp_q.valid !== 1'b1) begin
            err_count++;
            report_and_stop();
        end
    endtask

    task automatic w(ppl_tgt_t t, logic [15:0] d);
        acc(1'b1, PPL_SRC_LOCAL, t, d);
    endtask

    initial begin
        int i;
        gate.disp_ext_zero = 1'b1;
        repeat (5) @(negedge core_clk);
        rst_b = 1'b1;
        `CHK("level", PPL_RST_LEVEL, level_q)
        @(negedge core_clk);
        clk_en = 1'b0;
        cmd = '{1'b1, 1'b1, PPL_SRC_LOCAL, PPL_TGT_LEVEL, 16'h0003};
        go = 1'b1;
        @(negedge core_clk);
        go = 1'b0;
        clk_en = 1'b1;
        `CHK("frozen rsp", 1'b0, rsp_q.valid)
        `CHK("frozen lvl", PPL_RST_LEVEL, level_q)
        w(PPL_TGT_ENTRY, PW);
        `CHK("entry nolock", 1'b0, rsp_q.granted)
        gate.write_blocked = 1'b1;
        gate.read_blocked = 1'b1;
        w(PPL_TGT_OTHER, 16'h0001);
        `CHK("wprot", 1'b0, rsp_q.granted)
        acc(1'b0, PPL_SRC_RS485, PPL_TGT_OTHER, 16'h0000);
        `CHK("net read", 1'b1, rsp_q.granted)
        gate = '0;
        w(PPL_TGT_LEVEL, 16'h0065);
        `CHK("lvl ext", PPL_NO_LOCK, level_q)
        gate.disp_ext_zero = 1'b1;
        w(PPL_TGT_LEVEL, 16'h0065);
        `CHK("lvl 101", 16'h0065, level_q)
        w(PPL_TGT_ENTRY, 16'h0000);
        `CHK("entry 0", 1'b0, reg_q)
        w(PPL_TGT_ENTRY, PW);
        `CHK("reg", 1'b1, reg_q)
        for (i = 0; i < 3; i++) begin
            acc(1'b0, ppl_src_t'(i), PPL_TGT_OTHER, 16'h0000);
            `CHK("rd 101", 1'b1, rsp_q.granted)
            acc(1'b1, ppl_src_t'(i), PPL_TGT_OTHER, 16'h0001);
            `CHK("wr 101", 1'b1, rsp_q.lock_err)
        end
        w(PPL_TGT_LEVEL, 16'h0005);
        `CHK("lvl frozen", 16'h0065, level_q)
        w(PPL_TGT_COPY, 16'h0000);
        `CHK("copy", 1'b0, rsp_q.granted)
        gate.panel_unit_fitted = 1'b1;
        w(PPL_TGT_CONTRAST, 16'h0003);
        `CHK("contrast", 1'b1, rsp_q.granted)
        w(PPL_TGT_ENTRY, BAD);
        `CHK("bad pw", 1'b1, rsp_q.unlock_err)
        w(PPL_TGT_ENTRY, PW);
        `CHK("unlock", 1'b0, reg_q)
        acc(1'b0, PPL_SRC_LOCAL, PPL_TGT_ENTRY, 16'h0000);
        `CHK("open read", PPL_NO_LOCK, rsp_q.rdata)
        w(PPL_TGT_ENTRY, PW);
        for (i = 1; i <= 6; i++) begin
            w(PPL_TGT_ENTRY, BAD);
            `CHK("unlock err", 1'b1, rsp_q.unlock_err)
            acc(1'b0, PPL_SRC_LOCAL, PPL_TGT_ENTRY, 16'h0000);
            `CHK("count", (i > 5) ? 16'h0005 : 16'(i), rsp_q.rdata)
        end
        w(PPL_TGT_ENTRY, PW);
        `CHK("dead", 1'b1, reg_q)
        `CHK("dead err", 1'b1, rsp_q.unlock_err)
        gate.running = 1'b1;
        w(PPL_TGT_ALL_CLEAR, 16'h0000);
        `CHK("clr run", 1'b0, prst)
        gate.running = 1'b0;
        w(PPL_TGT_ALL_CLEAR, 16'h0000);
        `CHK("clr", 1'b1, prst)
        `CHK("clr lvl", PPL_NO_LOCK, level_q)
        w(PPL_TGT_LEVEL, 16'h0066);
        w(PPL_TGT_ENTRY, PW);
        for (i = 0; i < 3; i++) begin
            acc(1'b1, ppl_src_t'(i), PPL_TGT_OTHER, 16'h0001);
            `CHK("wr 102", i != 0, rsp_q.granted)
        end
        acc(1'b1, PPL_SRC_LOCAL, PPL_TGT_CLEAR, 16'h0000);
        `CHK("clr local", 1'b0, rsp_q.granted)
        acc(1'b1, PPL_SRC_RS485, PPL_TGT_CLEAR, 16'h0000);
        `CHK("clr net", 1'b1, rsp_q.granted)
        acc(1'b0, PPL_SRC_LOCAL, PPL_TGT_LEVEL, 16'h0000);
        `CHK("lvl read", 16'h0066, rsp_q.rdata)
        w(PPL_TGT_ENTRY, PW);
        `CHK("unlock 102", 1'b0, reg_q)
        gate.option_fitted = 1'b1;
        for (i = 0; i < 4; i++) begin
            w(PPL_TGT_LEVEL, lv[i]);
            w(PPL_TGT_ENTRY, PW);
            @(negedge core_clk);
            `CHK("jog", lv[i] == 16'h0004 || lv[i] == 16'h0069, jog)
            `CHK("trip", lv[i] == 16'h0000 || lv[i] == 16'h0064, trip)
            w(PPL_TGT_ENTRY, PW);
        end
        report_and_stop();
    end
endmodule
